/* hw/mdc_filter_cal.sv */
// Sinc decimation, calibration and result store of the muxed channel
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module mdc_filter_cal
  import mdc_pkg::*;
#(
  parameter logic [3:0] TEMP_SENSOR_SEL = 4'hA
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic conv_start,
  input wire logic [SLOT_W-1:0] step_slot,
  input wire logic [1:0] step_gain_sel,
  input wire logic [3:0] step_pos_input_sel,
  input wire logic [1:0] mux_chan_oversample_sel,
  input wire logic [DATA_W-1:0] mux_chan_offset_coef,
  input wire logic [DATA_W-1:0] mux_chan_gain_coef,
  input wire logic mod_bit,
  input wire logic [ADDR_W-1:0] reg_addr,
  output logic modulator_rate_clk,
  output logic [1:0] pga_gain_sel,
  output logic [3:0] pga_pos_sel,
  output logic conv_busy,
  output logic result_valid,
  output logic [DATA_W-1:0] result_data,
  output logic [DATA_W-1:0] reg_rdata
);
  // All assertions below share the main clock and its reset
  default clocking cb_main @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  //////////////////////////////////////////////////////////////////////////
  // Bitstream synchroniser
  logic [2:0] sync_q, sync_d;
  logic bit_q, bit_d;

  // Bit changes only when stages two and three agree
  always_comb begin
    sync_d = {sync_q[1:0], mod_bit};
    bit_d = bit_q;
    if (sync_q[1] == sync_q[2]) begin
      bit_d = sync_q[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync_q <= 3'h0;
      bit_q <= 1'b0;
    end else if (clk_en) begin
      sync_q <= sync_d;
      bit_q <= bit_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencing and filter state
  mdc_state_t state_q, state_d;
  logic phase_q, phase_d;
  logic [CYC_W-1:0] cyc_q, cyc_d;
  logic [DEC_W-1:0] tick_q, tick_d;
  logic [1:0] dec_q, dec_d;
  logic [3:0] s1_cnt_q, s1_cnt_d;
  logic signed [CIC_W-1:0] int1_q, int2_q, int3_q, int1_d, int2_d, int3_d;
  logic signed [CIC_W-1:0] z1_q, z2_q, z3_q, z1_d, z2_d, z3_d;
  logic signed [CIC_W-1:0] sinc3_out;
  logic signed [ACC_W-1:0] acc_q, acc_d;
  logic [1:0] gain_q, gain_d;
  logic [1:0] osr_q, osr_d;
  logic [3:0] sel_q, sel_d;
  logic [SLOT_W-1:0] slot_q, slot_d;

  // Phase restarts on trigger so each conversion sees whole periods
  always_comb begin
    state_d = state_q;
    phase_d = ~phase_q;
    cyc_d = cyc_q;
    tick_d = tick_q;
    dec_d = dec_q;
    s1_cnt_d = s1_cnt_q;
    int1_d = int1_q;
    int2_d = int2_q;
    int3_d = int3_q;
    z1_d = z1_q;
    z2_d = z2_q;
    z3_d = z3_q;
    sinc3_out = '0;
    acc_d = acc_q;
    gain_d = gain_q;
    osr_d = osr_q;
    sel_d = sel_q;
    slot_d = slot_q;
    case (state_q)
      MDC_IDLE: begin
        // Triggers while busy are ignored, never queued
        if (conv_start) begin
          state_d = MDC_CONV;
          phase_d = 1'b0;
          cyc_d = '0;
          tick_d = '0;
          dec_d = '0;
          s1_cnt_d = '0;
          int1_d = '0;
          int2_d = '0;
          int3_d = '0;
          z1_d = '0;
          z2_d = '0;
          z3_d = '0;
          acc_d = '0;
          gain_d = step_gain_sel;
          osr_d = mux_chan_oversample_sel;
          sel_d = step_pos_input_sel;
          slot_d = step_slot;
        end
      end
      MDC_CONV: begin
        if (phase_q) begin
          // Integrators chained so the comb sees this tick at once
          int1_d = int1_q + (bit_q ? CIC_W'(1) : '1);
          int2_d = int2_q + int1_d;
          int3_d = int3_q + int2_d;
          tick_d = tick_q + 6'h01;
          if (tick_q == DEC_LAST) begin
            z1_d = int3_d;
            z2_d = int3_d - z1_q;
            z3_d = z2_d - z2_q;
            sinc3_out = z3_d - z3_q;
            if (dec_q != SETTLE_IDX) begin
              dec_d = dec_q + 2'h1;
            end
            // Outputs before the third are not yet settled
            if (dec_q == SETTLE_IDX) begin
              acc_d = acc_q + ACC_W'(sinc3_out);
              s1_cnt_d = s1_cnt_q + 4'h1;
            end
          end
        end
        if (cyc_q == mdc_conv_last(osr_q)) begin
          state_d = MDC_CAL;
        end else begin
          cyc_d = cyc_q + 11'h001;
        end
      end
      MDC_CAL: begin
        state_d = MDC_IDLE;
      end
      default: begin
        state_d = MDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= MDC_IDLE;
      phase_q <= 1'b0;
      cyc_q <= '0;
      tick_q <= '0;
      dec_q <= '0;
      s1_cnt_q <= '0;
      int1_q <= '0;
      int2_q <= '0;
      int3_q <= '0;
      z1_q <= '0;
      z2_q <= '0;
      z3_q <= '0;
      acc_q <= '0;
      gain_q <= GAIN_SEL_1;
      osr_q <= OSR_64;
      sel_q <= 4'h0;
      slot_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      phase_q <= phase_d;
      cyc_q <= cyc_d;
      tick_q <= tick_d;
      dec_q <= dec_d;
      s1_cnt_q <= s1_cnt_d;
      int1_q <= int1_d;
      int2_q <= int2_d;
      int3_q <= int3_d;
      z1_q <= z1_d;
      z2_q <= z2_d;
      z3_q <= z3_d;
      acc_q <= acc_d;
      gain_q <= gain_d;
      osr_q <= osr_d;
      sel_q <= sel_d;
      slot_q <= slot_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Calibration: scale, offset, gain, round, clip
  logic signed [RAW_W-1:0] raw;
  logic signed [DIFF_W-1:0] ofs_w, diff, factor;
  logic signed [PROD_W-1:0] prod, scaled;
  logic [DATA_W-1:0] uncal, cal;
  logic bypass;
  logic [DATA_W-1:0] result_q, result_d;
  logic valid_q, valid_d;

  // Sum of N sinc3 outputs scaled back to 16-bit code weight
  always_comb begin
    raw = RAW_W'(acc_q >>> (SINC3_SHIFT + int'(osr_q)));
    ofs_w = DIFF_W'($signed(mux_chan_offset_coef));
    if (gain_q == GAIN_SEL_4) begin
      ofs_w = ofs_w <<< 1;
    end
    diff = DIFF_W'(raw) - ofs_w;
    factor = GAIN_ONE + DIFF_W'($signed(mux_chan_gain_coef));
    prod = PROD_W'(diff) * PROD_W'(factor);
    scaled = (prod + ROUND_HALF) >>> GAIN_FRAC;
    uncal = mdc_sat(PROD_W'(raw));
    cal = mdc_sat(scaled);
    bypass = (sel_q == TEMP_SENSOR_SEL);
    result_d = result_q;
    valid_d = 1'b0;
    if (state_q == MDC_CAL) begin
      result_d = bypass ? uncal : cal;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      result_q <= '0;
      valid_q <= 1'b0;
    end else if (clk_en) begin
      result_q <= result_d;
      valid_q <= valid_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result store and read port
  logic rd_hit_q, rd_hit_d;
  logic [DATA_W-1:0] mem_rdata;
  logic [ADDR_W-1:0] rd_off;

  // Addresses outside the result window read as zero
  always_comb begin
    rd_off = reg_addr - RESULT_BASE;
    rd_hit_d = (reg_addr >= RESULT_BASE) && (reg_addr <= RESULT_LAST);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_hit_q <= 1'b0;
    end else if (clk_en) begin
      rd_hit_q <= rd_hit_d;
    end
  end

  mdc_result_mem #(.AW(SLOT_W), .DW(DATA_W)) u_mem (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .wr_en(state_q == MDC_CAL),
    .wr_addr(slot_q),
    .wr_data(result_d),
    .rd_addr(rd_off[SLOT_W-1:0]),
    .rd_data_q(mem_rdata)
  );

  // Outputs
  assign reg_rdata = rd_hit_q ? mem_rdata : '0;
  assign modulator_rate_clk = phase_q;
  assign pga_gain_sel = gain_q;
  assign pga_pos_sel = sel_q;
  assign conv_busy = (state_q != MDC_IDLE);
  assign result_valid = valid_q;
  assign result_data = result_q;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_single_shot;
    $rose(conv_busy) |-> $past(conv_start);
  endproperty
  a_single_shot: assert property (p_single_shot)
    else $error("conversion began without trigger");
  property p_mod_half;
    (clk_en && state_q == MDC_CONV) |=> (phase_q != $past(phase_q));
  endproperty
  a_mod_half: assert property (p_mod_half)
    else $error("modulator clock missed a toggle");
  property p_clear;
    (clk_en && state_q == MDC_IDLE && conv_start) |=>
      (int3_q == '0 && z3_q == '0 && acc_q == '0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("filter not cleared at start");
  property p_len64;
    (clk_en && state_q == MDC_IDLE && conv_start &&
     mux_chan_oversample_sel == OSR_64) ##1 (clk_en [*8]) |->
      (cyc_q == 11'h007);
  endproperty
  a_len64: assert property (p_len64)
    else $error("cycle counter off during conversion");
  property p_end;
    (clk_en && state_q == MDC_CONV && cyc_q == mdc_conv_last(osr_q))
      |=> state_q == MDC_CAL;
  endproperty
  a_end: assert property (p_end)
    else $error("conversion length wrong");
  property p_sinc1;
    (state_q == MDC_CAL) |-> (s1_cnt_q == (4'h1 << osr_q));
  endproperty
  a_sinc1: assert property (p_sinc1)
    else $error("wrong number of sinc1 terms");
  property p_settled;
    $rose(result_valid) |-> $past(state_q == MDC_CAL);
  endproperty
  a_settled: assert property (p_settled)
    else $error("result delivered before settling");
  property p_bypass;
    (clk_en && state_q == MDC_CAL && bypass) |=>
      (result_q == $past(uncal));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("temperature result was corrected");
  property p_unity;
    (clk_en && state_q == MDC_CAL && mux_chan_offset_coef == '0 &&
     mux_chan_gain_coef == '0) |=> (result_q == $past(uncal));
  endproperty
  a_unity: assert property (p_unity)
    else $error("zero coefficients changed the result");
  property p_clip;
    (clk_en && state_q == MDC_CAL && !bypass &&
     scaled > PROD_W'(POS_FS)) |=> (result_q == POS_FS);
  endproperty
  a_clip: assert property (p_clip)
    else $error("positive overrange not clipped");

  c_conv64: cover property (state_q == MDC_CAL && osr_q == OSR_64);
  c_conv512: cover property (state_q == MDC_CAL && osr_q == OSR_512);
  c_temp: cover property (state_q == MDC_CAL && bypass);
  c_read: cover property (rd_hit_q && reg_rdata != '0);

endmodule : mdc_filter_cal
`default_nettype wire

/* hw/mdc_pkg.sv */
// Constants, types and helpers for the multiplexed converter back end
package mdc_pkg;

  localparam int DATA_W = 16;
  localparam int CIC_W = 20;
  localparam int ACC_W = 23;
  localparam int RAW_W = 17;
  localparam int DIFF_W = 18;
  localparam int PROD_W = 36;
  localparam int CYC_W = 11;
  localparam int SLOT_W = 5;
  localparam int ADDR_W = 6;
  localparam int DEC_W = 6;

  // Result slots in the register space
  localparam logic [ADDR_W-1:0] RESULT_BASE = 6'h10;
  localparam logic [ADDR_W-1:0] RESULT_LAST = 6'h2F;

  // Oversampling field codes
  localparam logic [1:0] OSR_64 = 2'h0;
  localparam logic [1:0] OSR_128 = 2'h1;
  localparam logic [1:0] OSR_256 = 2'h2;
  localparam logic [1:0] OSR_512 = 2'h3;

  // Step gain field codes
  localparam logic [1:0] GAIN_SEL_1 = 2'h0;
  localparam logic [1:0] GAIN_SEL_2 = 2'h1;
  localparam logic [1:0] GAIN_SEL_4 = 2'h2;

  // Conversion times in main clock periods
  localparam logic [CYC_W-1:0] CONV_MCLK_64 = 11'h180;
  localparam logic [CYC_W-1:0] CONV_MCLK_128 = 11'h200;
  localparam logic [CYC_W-1:0] CONV_MCLK_256 = 11'h300;
  localparam logic [CYC_W-1:0] CONV_MCLK_512 = 11'h500;

  // Sinc3 decimation and settling
  localparam logic [DEC_W-1:0] DEC_LAST = 6'h3F;
  localparam logic [1:0] SETTLE_IDX = 2'h2;
  localparam int SINC3_SHIFT = 3;

  // Calibration arithmetic
  localparam logic signed [DIFF_W-1:0] GAIN_ONE = 18'h1_0000;
  localparam logic signed [PROD_W-1:0] ROUND_HALF = 36'h0_0000_8000;
  localparam int GAIN_FRAC = 16;
  localparam logic signed [DATA_W-1:0] POS_FS = 16'h7FFF;
  localparam logic signed [DATA_W-1:0] NEG_FS = 16'h8000;

  typedef enum logic [1:0] {MDC_IDLE, MDC_CONV, MDC_CAL} mdc_state_t;

  // Last cycle index of a conversion for a given ratio
  function automatic logic [CYC_W-1:0] mdc_conv_last(input logic [1:0] osr);
    logic [CYC_W-1:0] len;
    case (osr)
      OSR_64: len = CONV_MCLK_64;
      OSR_128: len = CONV_MCLK_128;
      OSR_256: len = CONV_MCLK_256;
      default: len = CONV_MCLK_512;
    endcase
    return len - 11'h001;
  endfunction : mdc_conv_last

  // Clip a wide signed value to the 16-bit code range
  function automatic logic [DATA_W-1:0] mdc_sat(
      input logic signed [PROD_W-1:0] v);
    logic [DATA_W-1:0] r;
    if (v > PROD_W'(POS_FS)) r = POS_FS;
    else if (v < PROD_W'(NEG_FS)) r = NEG_FS;
    else r = v[DATA_W-1:0];
    return r;
  endfunction : mdc_sat

endpackage : mdc_pkg

/* hw/mdc_result_mem.sv */
// Result store for the sequence steps, registered read
`timescale 1ns/1ns
`default_nettype none
module mdc_result_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic core_clk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_q
);
  logic [DW-1:0] mem [2**AW];

  // Contents are volatile and not cleared by reset
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule : mdc_result_mem
`default_nettype wire

/* tb/mdc_mod_model.sv */
// Behavioural modulator: periodic one-bit stream on the modulator clock
`timescale 1ns/1ns
`default_nettype none
module mdc_mod_model (
  input wire logic mod_clk,
  input wire logic [2:0] ones,
  output logic mod_bit
);
  logic [1:0] phase_q = 2'h0;
  initial mod_bit = 1'b0;
  // Period of four: every 64-sample window holds the same density
  always @(posedge mod_clk) begin
    phase_q <= phase_q + 2'h1;
    mod_bit <= #3 ({1'b0, phase_q} < ones);
  end
endmodule : mdc_mod_model
`default_nettype wire

/* tb/mux_adc_decimation_calibration_bench.sv */
// Self-checking bench for the muxed converter filter and calibration
`timescale 1ns/1ns
`default_nettype none
module mux_adc_decimation_calibration_bench
  import mdc_pkg::*;
();
  localparam logic [3:0] TEMP_SEL = 4'hA;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic conv_start = 1'b0;
  logic [4:0] step_slot = 5'h00;
  logic [1:0] step_gain_sel = 2'h0;
  logic [3:0] step_pos_input_sel = 4'h1;
  logic [1:0] mux_chan_oversample_sel = 2'h0;
  logic [15:0] mux_chan_offset_coef = 16'h0000;
  logic [15:0] mux_chan_gain_coef = 16'h0000;
  logic [5:0] reg_addr = 6'h00;
  logic [2:0] ones = 3'h2;
  logic mod_bit, modulator_rate_clk, conv_busy, result_valid;
  logic [1:0] pga_gain_sel;
  logic [3:0] pga_pos_sel;
  logic [15:0] result_data, reg_rdata;
  logic [15:0] lfsr_q = 16'h0032;
  logic [15:0] shadow [32];
  logic [31:0] written = 32'h0000_0000;
  int errors = 0;
  int num_checks = 0;
  int conv_len [4] = '{384, 512, 768, 1280};

  //////////////////////////////////////////////////////////////////////////
  // Design, modulator model and clock
  mdc_filter_cal #(.TEMP_SENSOR_SEL(TEMP_SEL)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .conv_start(conv_start), .step_slot(step_slot),
    .step_gain_sel(step_gain_sel), .step_pos_input_sel(step_pos_input_sel),
    .mux_chan_oversample_sel(mux_chan_oversample_sel),
    .mux_chan_offset_coef(mux_chan_offset_coef),
    .mux_chan_gain_coef(mux_chan_gain_coef), .mod_bit(mod_bit),
    .reg_addr(reg_addr), .modulator_rate_clk(modulator_rate_clk),
    .pga_gain_sel(pga_gain_sel), .pga_pos_sel(pga_pos_sel),
    .conv_busy(conv_busy), .result_valid(result_valid),
    .result_data(result_data), .reg_rdata(reg_rdata));
  mdc_mod_model u_mod (.mod_clk(modulator_rate_clk), .ones(ones),
    .mod_bit(mod_bit));
  // 25 MHz main clock
  always #20 core_clk = ~core_clk;

  //////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd
  // Raw is 16384 per density step away from half; offset doubles at gain 4
  function automatic logic [15:0] expect_code(input int k,
      input logic [1:0] gs, input logic [3:0] ps);
    longint d, p;
    d = 16384 * (k - 2);
    p = d;
    if (ps != TEMP_SEL) begin
      d = d - longint'($signed(mux_chan_offset_coef)) *
        (gs == GAIN_SEL_4 ? 2 : 1);
      p = (d * (65536 + longint'($signed(mux_chan_gain_coef))) + 32768) >>> 16;
    end
    if (p > 32767) p = 32767;
    else if (p < -32768) p = -32768;
    return p[15:0];
  endfunction : expect_code
  task automatic check(input logic [15:0] seen, input logic [15:0] want,
      input string what);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // One triggered conversion; poke retriggers mid-run with other settings
  task automatic convert(input int k, input logic [1:0] gs,
      input logic [3:0] ps, input logic [1:0] osr, input logic [4:0] slot,
      input bit poke, input bit stall, input bit b2b);
    int n;
    int tog_bad;
    logic last_clk;
    logic [15:0] want;
    want = expect_code(k, gs, ps);
    if (!b2b) begin
      ones = k[2:0];
      repeat (4) @(negedge core_clk);
    end
    step_gain_sel = gs;
    step_pos_input_sel = ps;
    mux_chan_oversample_sel = osr;
    step_slot = slot;
    conv_start = 1'b1;
    @(negedge core_clk);
    check({15'h0000, conv_busy}, 16'h0001, "busy");
    n = 0;
    tog_bad = 0;
    last_clk = modulator_rate_clk;
    while (result_valid !== 1'b1 && n < 1400) begin
      conv_start = poke && n == 7;
      if (poke && n == 7) begin
        step_gain_sel = GAIN_SEL_4;
        step_pos_input_sel = TEMP_SEL;
        mux_chan_oversample_sel = ~osr;
      end
      clk_en = !stall || rnd() % 4 != 0;
      @(negedge core_clk);
      if (clk_en) begin
        n++;
        tog_bad += (modulator_rate_clk === last_clk);
        last_clk = modulator_rate_clk;
      end
    end
    clk_en = 1'b1;
    check(16'(n), 16'(conv_len[osr] + 1), "latency");
    check(result_data, want, "result");
    check({15'h0000, conv_busy}, 16'h0000, "idle");
    check({10'h000, pga_gain_sel, pga_pos_sel},
      {10'h000, gs, ps}, "pga");
    check(16'(tog_bad), 16'h0000, "mod clock");
    shadow[slot] = want;
    written[slot] = 1'b1;
  endtask : convert

  //////////////////////////////////////////////////////////////////////////
  // Watchdog, reckoned from about 30k cycles of expected run
  initial begin
    #(90000 * 40);
    errors++;
    $display("MISMATCH at %0t: watchdog", $time);
    wrap_up();
  end

  // Main sequence
  initial begin
    int i;
    longint acc;
    int ck [8] = '{4, 0, 2, 2, 2, 3, 1, 3};
    logic [15:0] co [8] = '{16'h0000, 16'h0000, 16'h0010, 16'hFFF0, 16'h0010,
      16'h0001, 16'h0000, 16'h1234};
    logic [15:0] cg [8] = '{16'h0000, 16'h7FFF, 16'h0000, 16'h0000, 16'h0000,
      16'h8000, 16'h8000, 16'h7FFF};
    logic [1:0] cs [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0};
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    check({14'h0000, conv_busy, result_valid}, 16'h0000, "reset flags");
    check(result_data, 16'h0000, "reset data");
    // Host reload after reset, zeroed before calibrating
    acc = 0;
    for (i = 0; i < 4; i++) begin
      convert(3, GAIN_SEL_1, 4'h9, OSR_64, 5'(i), 1'b0, i[0], i > 0);
      acc += $signed(result_data);
    end
    mux_chan_offset_coef = 16'(acc / 4);
    convert(3, GAIN_SEL_2, 4'h9, OSR_64, 5'h04, 1'b0, 1'b0, 1'b1);
    check(result_data, 16'h0000, "offset cal");
    mux_chan_offset_coef = 16'h0000;
    convert(3, GAIN_SEL_1, 4'h2, OSR_64, 5'h05, 1'b0, 1'b0, 1'b1);
    mux_chan_gain_coef = 16'(18022 * 65536 / $signed(result_data) - 65536);
    convert(3, GAIN_SEL_1, 4'h2, OSR_64, 5'h06, 1'b0, 1'b0, 1'b1);
    check(result_data, 16'h4666, "gain cal");
    $display("test calibration done");
    // Clipping, offset sign and weight, gain extremes, half rounding, bypass
    for (i = 0; i < 8; i++) begin
      mux_chan_offset_coef = co[i];
      mux_chan_gain_coef = cg[i];
      convert(ck[i], cs[i], i == 7 ? TEMP_SEL : 4'h1, OSR_64, 5'(8 + i),
        1'b0, 1'b0, 1'b0);
    end
    $display("test corners done");
    // Every ratio, with an ignored trigger in mid conversion
    for (i = 0; i < 4; i++) begin
      convert(2, GAIN_SEL_1, 4'h3, 2'(i), 5'(16 + i), 1'b1, 1'b0, 1'b0);
    end
    $display("test ratios done");
    // Random settings, stalls and coefficients
    for (i = 0; i < 24; i++) begin
      mux_chan_offset_coef = rnd();
      mux_chan_gain_coef = rnd();
      convert(int'(rnd() % 5), 2'(rnd() % 3), 4'(rnd()), 2'(rnd()),
        5'(rnd()), rnd() % 2 == 0, rnd() % 2 == 0, 1'b0);
    end
    $display("test random done");
    // Register space sweep, unmapped addresses read zero
    for (i = 0; i < 64; i++) begin
      reg_addr = 6'(i);
      @(negedge core_clk);
      if (i < 16 || i > 47) begin
        check(reg_rdata, 16'h0000, "unmapped");
      end else if (written[i - 16]) begin
        check(reg_rdata, shadow[i - 16], "stored");
      end
    end
    $display("test readback done");
    wrap_up();
  end
endmodule : mux_adc_decimation_calibration_bench
`default_nettype wire
